//--- hdl/lsbm_pkg.sv
// Constants and types for the bank skew and sample LSB marker block
package lsbm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [8:0] IDX_B4_SKEW_M90 = 9'h143;
    localparam logic [8:0] IDX_B5_SKEW_P0  = 9'h152;
    localparam logic [8:0] IDX_B5_SKEW_M90 = 9'h153;
    localparam logic [8:0] IDX_LSB_CTRL    = 9'h160;
    localparam logic [8:0] IDX_CONFIG      = 9'h170;
    localparam logic [8:0] IDX_STATUS      = 9'h171;

    // Bus address slice
    localparam int ADR_W    = 11;
    localparam int ADR_LO   = 2;
    localparam int REG_W    = 8;
    localparam int SAMPLE_W = 12;
    localparam int NARROW_W = 8;
    localparam int CS_W     = 2;

    // Field positions
    localparam int LSB_CTRL_MARKER_EN = 0;
    localparam int CFG_PHASE_M90      = 0;
    localparam int CFG_NARROW         = 1;
    localparam int CFG_CAL_STATE_EN   = 2;
    localparam int CFG_MARKER_RX_EN   = 3;
    localparam int STAT_OUT_VALID     = 0;
    localparam int STAT_IN_READY      = 1;
    localparam int STAT_MARKER_ACTIVE = 2;
    localparam int STAT_TRIM_LOADED   = 3;

    // Reset values
    localparam logic [REG_W-1:0]    LSB_CTRL_RST = 8'h00;
    localparam logic [REG_W-1:0]    CONFIG_RST   = 8'h00;
    localparam logic [REG_W-1:0]    SKEW_RST     = 8'h00;
    localparam logic [CS_W-1:0]     ILA_CS_VALUE = 2'h0;
    localparam logic [31:0]         WORD_ZERO    = 32'h0000_0000;

    // Sample LSB source
    typedef enum logic [1:0] {
        LSB_SRC_DATA   = 2'b00,
        LSB_SRC_MARKER = 2'b01,
        LSB_SRC_CAL    = 2'b10
    } lsbm_lsb_src_t;
endpackage

//--- hdl/lsbm_stream_if.sv
// Valid/ready stream carrier between the block's modules
`timescale 1ns/1ps
interface lsbm_stream_if #(parameter int W = 13);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface

//--- hdl/lsbm_fifo2.sv
// Two-entry flip-flop buffer with valid and ready on both sides
`timescale 1ns/1ps
module lsbm_fifo2 #(parameter int W = 13) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    // Streams
    lsbm_stream_if.rx   s_in,
    lsbm_stream_if.tx   s_out
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic         wr_ptr_r;
    logic         wr_ptr_nxt;
    logic         rd_ptr_r;
    logic         rd_ptr_nxt;
    logic [1:0]   count_r;
    logic [1:0]   count_nxt;
    logic         push;
    logic         pop;

    assign s_in.ready  = (count_r != 2'h2);
    assign s_out.valid = (count_r != 2'h0);
    assign s_out.data  = mem_r[rd_ptr_r];

    always_comb begin
        push       = s_in.valid && s_in.ready;
        pop        = s_out.valid && s_out.ready;
        mem_nxt    = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push) begin
            mem_nxt[wr_ptr_r] = s_in.data;
            wr_ptr_nxt        = ~wr_ptr_r;
        end
        if (pop) begin
            rd_ptr_nxt = ~rd_ptr_r;
        end
        if (push && !pop) begin
            count_nxt = count_r + 2'h1;
        end else if (pop && !push) begin
            count_nxt = count_r - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else if (ce) begin
            mem_r    <= mem_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end
endmodule

//--- hdl/lsbm_skew_reg.sv
// One trimmed, software-writable skew register
`timescale 1ns/1ps
module lsbm_skew_reg (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // Trim and write
    input  wire logic                        load_trim,
    input  wire logic [lsbm_pkg::REG_W-1:0]  trim,
    input  wire logic                        wr_en,
    input  wire logic [lsbm_pkg::REG_W-1:0]  wr_data,
    // Value
    output logic      [lsbm_pkg::REG_W-1:0]  q
);
    logic [lsbm_pkg::REG_W-1:0] q_r;
    logic [lsbm_pkg::REG_W-1:0] q_nxt;

    assign q = q_r;

    always_comb begin
        q_nxt = q_r;
        if (load_trim) begin
            q_nxt = trim;
        end else if (wr_en) begin
            q_nxt = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= lsbm_pkg::SKEW_RST;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end
endmodule

//--- hdl/lsbm_top.sv
// Bank skew registers and sample LSB marker insertion with a Wishbone slave
`timescale 1ns/1ps
module lsbm_top (
    // Clock, reset, enable
    input  wire logic                             CLK_I,
    input  wire logic                             RST_N_I,
    input  wire logic                             CE_I,
    // Wishbone slave
    input  wire logic [lsbm_pkg::ADR_W-1:0]       ADR_I,
    input  wire logic [31:0]                      DAT_I,
    output logic      [31:0]                      DAT_O,
    input  wire logic                             WE_I,
    input  wire logic [3:0]                       SEL_I,
    input  wire logic                             CYC_I,
    input  wire logic                             STB_I,
    output logic                                  ACK_O,
    output logic                                  ERR_O,
    // Factory trim values
    input  wire logic [lsbm_pkg::REG_W-1:0]       TRIM_B4_M90_I,
    input  wire logic [lsbm_pkg::REG_W-1:0]       TRIM_B5_P0_I,
    input  wire logic [lsbm_pkg::REG_W-1:0]       TRIM_B5_M90_I,
    // Applied skew values
    output logic      [lsbm_pkg::REG_W-1:0]       SKEW_B4_O,
    output logic                                  SKEW_B4_EN_O,
    output logic      [lsbm_pkg::REG_W-1:0]       SKEW_B5_O,
    // Sample input
    input  wire logic [lsbm_pkg::SAMPLE_W-1:0]    SMP_DATA_I,
    input  wire logic                             SMP_MARKER_I,
    input  wire logic                             SMP_CAL_STATE_I,
    input  wire logic                             SMP_VALID_I,
    output logic                                  SMP_READY_O,
    // Sample output
    output logic      [lsbm_pkg::SAMPLE_W-1:0]    OUT_DATA_O,
    output logic                                  OUT_VALID_O,
    input  wire logic                             OUT_READY_I,
    // Lane alignment control-bit count
    output logic      [lsbm_pkg::CS_W-1:0]        ILA_CS_O
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [lsbm_pkg::REG_W-1:0] lsb_ctrl_r;
    logic [lsbm_pkg::REG_W-1:0] lsb_ctrl_nxt;
    logic [lsbm_pkg::REG_W-1:0] config_r;
    logic [lsbm_pkg::REG_W-1:0] config_nxt;
    logic                       ack_r;
    logic                       ack_nxt;
    logic                       err_r;
    logic                       err_nxt;
    logic [31:0]                dat_r;
    logic [31:0]                dat_nxt;
    logic                       trim_load_r;
    logic                       trim_load_nxt;
    logic                       trim_done_r;
    logic                       trim_done_nxt;
    logic [8:0]                 idx;
    logic                       req;
    logic                       hit;
    logic                       wr_commit;
    logic                       wr_b4_m90;
    logic                       wr_b5_p0;
    logic                       wr_b5_m90;
    logic [lsbm_pkg::REG_W-1:0] b4_m90_q;
    logic [lsbm_pkg::REG_W-1:0] b5_p0_q;
    logic [lsbm_pkg::REG_W-1:0] b5_m90_q;
    logic [lsbm_pkg::REG_W-1:0] rd_val;
    logic [lsbm_pkg::REG_W-1:0] status;
    logic                       phase_m90;
    logic                       narrow;
    logic                       marker_on;
    logic                       cal_on;
    lsbm_pkg::lsbm_lsb_src_t    lsb_src;
    logic                       lsb_bit;
    logic [lsbm_pkg::SAMPLE_W-1:0] framed;

    lsbm_stream_if #(.W(lsbm_pkg::SAMPLE_W)) s_in ();
    lsbm_stream_if #(.W(lsbm_pkg::SAMPLE_W)) s_out ();

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign idx       = ADR_I[lsbm_pkg::ADR_W-1:lsbm_pkg::ADR_LO];
    assign req       = CYC_I && STB_I;
    assign hit       = (idx == lsbm_pkg::IDX_B4_SKEW_M90) || (idx == lsbm_pkg::IDX_B5_SKEW_P0)
                    || (idx == lsbm_pkg::IDX_B5_SKEW_M90) || (idx == lsbm_pkg::IDX_LSB_CTRL)
                    || (idx == lsbm_pkg::IDX_CONFIG) || (idx == lsbm_pkg::IDX_STATUS);
    // Write commits at the edge where the master sees ack
    assign wr_commit = req && WE_I && ack_r && SEL_I[0] && !trim_load_r;
    assign wr_b4_m90 = wr_commit && (idx == lsbm_pkg::IDX_B4_SKEW_M90);
    assign wr_b5_p0  = wr_commit && (idx == lsbm_pkg::IDX_B5_SKEW_P0);
    assign wr_b5_m90 = wr_commit && (idx == lsbm_pkg::IDX_B5_SKEW_M90);

    assign status = {4'h0, trim_done_r, marker_on, s_in.ready, s_out.valid};

    always_comb begin
        unique case (idx)
            lsbm_pkg::IDX_B4_SKEW_M90: rd_val = b4_m90_q;
            lsbm_pkg::IDX_B5_SKEW_P0:  rd_val = b5_p0_q;
            lsbm_pkg::IDX_B5_SKEW_M90: rd_val = b5_m90_q;
            lsbm_pkg::IDX_LSB_CTRL:    rd_val = lsb_ctrl_r;
            lsbm_pkg::IDX_CONFIG:      rd_val = config_r;
            lsbm_pkg::IDX_STATUS:      rd_val = status;
            default:                   rd_val = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer and control registers
    always_comb begin
        ack_nxt       = 1'b0;
        err_nxt       = 1'b0;
        dat_nxt       = dat_r;
        lsb_ctrl_nxt  = lsb_ctrl_r;
        config_nxt    = config_r;
        trim_load_nxt = 1'b0;
        trim_done_nxt = trim_done_r || trim_load_r;
        if (req && !ack_r && !err_r) begin
            ack_nxt = hit;
            err_nxt = !hit;
            dat_nxt = {24'h00_0000, rd_val};
        end
        if (wr_commit && idx == lsbm_pkg::IDX_LSB_CTRL) begin
            lsb_ctrl_nxt = DAT_I[lsbm_pkg::REG_W-1:0];
        end
        if (wr_commit && idx == lsbm_pkg::IDX_CONFIG) begin
            config_nxt = DAT_I[lsbm_pkg::REG_W-1:0];
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_r       <= 1'b0;
            err_r       <= 1'b0;
            dat_r       <= lsbm_pkg::WORD_ZERO;
            lsb_ctrl_r  <= lsbm_pkg::LSB_CTRL_RST;
            config_r    <= lsbm_pkg::CONFIG_RST;
            trim_load_r <= 1'b1;
            trim_done_r <= 1'b0;
        end else if (CE_I) begin
            ack_r       <= ack_nxt;
            err_r       <= err_nxt;
            dat_r       <= dat_nxt;
            lsb_ctrl_r  <= lsb_ctrl_nxt;
            config_r    <= config_nxt;
            trim_load_r <= trim_load_nxt;
            trim_done_r <= trim_done_nxt;
        end
    end

    assign ACK_O = ack_r;
    assign ERR_O = err_r;
    assign DAT_O = dat_r;

    ////////////////////////////////////////////////////////////////////////////
    // Skew registers and phase selection
    lsbm_skew_reg u_b4_m90 (
        .clk       (CLK_I),
        .rst_n     (RST_N_I),
        .ce        (CE_I),
        .load_trim (trim_load_r),
        .trim      (TRIM_B4_M90_I),
        .wr_en     (wr_b4_m90),
        .wr_data   (DAT_I[lsbm_pkg::REG_W-1:0]),
        .q         (b4_m90_q)
    );

    lsbm_skew_reg u_b5_p0 (
        .clk       (CLK_I),
        .rst_n     (RST_N_I),
        .ce        (CE_I),
        .load_trim (trim_load_r),
        .trim      (TRIM_B5_P0_I),
        .wr_en     (wr_b5_p0),
        .wr_data   (DAT_I[lsbm_pkg::REG_W-1:0]),
        .q         (b5_p0_q)
    );

    lsbm_skew_reg u_b5_m90 (
        .clk       (CLK_I),
        .rst_n     (RST_N_I),
        .ce        (CE_I),
        .load_trim (trim_load_r),
        .trim      (TRIM_B5_M90_I),
        .wr_en     (wr_b5_m90),
        .wr_data   (DAT_I[lsbm_pkg::REG_W-1:0]),
        .q         (b5_m90_q)
    );

    assign phase_m90    = config_r[lsbm_pkg::CFG_PHASE_M90];
    assign SKEW_B4_EN_O = phase_m90;
    assign SKEW_B4_O    = phase_m90 ? b4_m90_q : lsbm_pkg::SKEW_RST;
    assign SKEW_B5_O    = phase_m90 ? b5_m90_q : b5_p0_q;

    ////////////////////////////////////////////////////////////////////////////
    // LSB source selection and sample framing
    assign narrow    = config_r[lsbm_pkg::CFG_NARROW];
    // Marker honoured only with its input receiver enabled
    assign marker_on = lsb_ctrl_r[lsbm_pkg::LSB_CTRL_MARKER_EN]
                    && config_r[lsbm_pkg::CFG_MARKER_RX_EN];
    assign cal_on    = config_r[lsbm_pkg::CFG_CAL_STATE_EN];

    always_comb begin
        if (marker_on) begin
            lsb_src = lsbm_pkg::LSB_SRC_MARKER;
        end else if (cal_on) begin
            lsb_src = lsbm_pkg::LSB_SRC_CAL;
        end else begin
            lsb_src = lsbm_pkg::LSB_SRC_DATA;
        end
        unique case (lsb_src)
            lsbm_pkg::LSB_SRC_MARKER: lsb_bit = SMP_MARKER_I;
            lsbm_pkg::LSB_SRC_CAL:    lsb_bit = SMP_CAL_STATE_I;
            lsbm_pkg::LSB_SRC_DATA:   lsb_bit = SMP_DATA_I[0];
            default:                  lsb_bit = SMP_DATA_I[0];
        endcase
        framed = {SMP_DATA_I[lsbm_pkg::SAMPLE_W-1:1], lsb_bit};
        if (narrow) begin
            framed = {{(lsbm_pkg::SAMPLE_W-lsbm_pkg::NARROW_W){1'b0}},
                      SMP_DATA_I[lsbm_pkg::NARROW_W-1:1], lsb_bit};
        end
    end

    // Marker rides in the same word as its sample through the buffer
    assign s_in.valid  = SMP_VALID_I;
    assign s_in.data   = framed;
    assign SMP_READY_O = s_in.ready;

    lsbm_fifo2 #(.W(lsbm_pkg::SAMPLE_W)) u_buf (
        .clk   (CLK_I),
        .rst_n (RST_N_I),
        .ce    (CE_I),
        .s_in  (s_in),
        .s_out (s_out)
    );

    assign OUT_VALID_O = s_out.valid;
    assign OUT_DATA_O  = s_out.data;
    assign s_out.ready = OUT_READY_I;

    assign ILA_CS_O = lsbm_pkg::ILA_CS_VALUE;
endmodule

//--- verif/lsbm_top_asserts.sv
// Concurrent checks on the ports of the skew and marker block
`timescale 1ns/1ps
module lsbm_top_asserts (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        CE_I,
    // Register bus
    input  wire logic [10:0] ADR_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        ACK_O,
    input  wire logic        ERR_O,
    // Skew
    input  wire logic [7:0]  TRIM_B4_M90_I,
    input  wire logic [7:0]  TRIM_B5_P0_I,
    input  wire logic [7:0]  TRIM_B5_M90_I,
    input  wire logic [7:0]  SKEW_B4_O,
    input  wire logic        SKEW_B4_EN_O,
    input  wire logic [7:0]  SKEW_B5_O,
    // Samples
    input  wire logic [11:0] SMP_DATA_I,
    input  wire logic        SMP_MARKER_I,
    input  wire logic        SMP_CAL_STATE_I,
    input  wire logic        SMP_VALID_I,
    input  wire logic        SMP_READY_O,
    input  wire logic [11:0] OUT_DATA_O,
    input  wire logic        OUT_VALID_O,
    input  wire logic        OUT_READY_I,
    input  wire logic [1:0]  ILA_CS_O
);
    logic [7:0]  b4_r, b5a_r, b5b_r, cfg_r, ctl_r;
    logic        ld_r, wr, lsb, take0, mapped;
    logic [8:0]  idx;
    logic [11:0] exp_w;
    ////////////////////////////////////////////////////////////////////////////
    assign idx    = ADR_I[10:2];
    assign mapped = idx inside {lsbm_pkg::IDX_B4_SKEW_M90, lsbm_pkg::IDX_B5_SKEW_P0,
        lsbm_pkg::IDX_B5_SKEW_M90, lsbm_pkg::IDX_LSB_CTRL, lsbm_pkg::IDX_CONFIG,
        lsbm_pkg::IDX_STATUS};
    assign wr     = ld_r && CYC_I && STB_I && ACK_O && WE_I && SEL_I[0];
    assign lsb    = (ctl_r[0] && cfg_r[3]) ? SMP_MARKER_I
                  : (cfg_r[2] ? SMP_CAL_STATE_I : SMP_DATA_I[0]);
    assign exp_w  = cfg_r[1] ? {4'h0, SMP_DATA_I[7:1], lsb} : {SMP_DATA_I[11:1], lsb};
    assign take0  = CE_I && SMP_VALID_I && SMP_READY_O && !OUT_VALID_O;
    // Shadow of the register contents
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {b4_r, b5a_r, b5b_r, cfg_r, ctl_r} <= '0;
            ld_r <= 1'b0;
        end else if (!ld_r) begin
            b4_r  <= TRIM_B4_M90_I;
            b5a_r <= TRIM_B5_P0_I;
            b5b_r <= TRIM_B5_M90_I;
            ld_r  <= 1'b1;
        end else if (wr) begin
            case (idx)
                lsbm_pkg::IDX_B4_SKEW_M90: b4_r  <= DAT_I[7:0];
                lsbm_pkg::IDX_B5_SKEW_P0:  b5a_r <= DAT_I[7:0];
                lsbm_pkg::IDX_B5_SKEW_M90: b5b_r <= DAT_I[7:0];
                lsbm_pkg::IDX_LSB_CTRL:    ctl_r <= DAT_I[7:0];
                lsbm_pkg::IDX_CONFIG:      cfg_r <= DAT_I[7:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_b4_gate: assert property (ld_r |-> SKEW_B4_EN_O == cfg_r[0] &&
        SKEW_B4_O == (cfg_r[0] ? b4_r : 8'h00)) else $error("bank4 skew wrong");
    a_b5_select: assert property (ld_r |->
        SKEW_B5_O == (cfg_r[0] ? b5b_r : b5a_r)) else $error("bank5 skew wrong");
    a_ila_zero: assert property (ILA_CS_O == 2'h0) else $error("ila cs not zero");
    a_first_word: assert property (take0 |=> OUT_VALID_O) else $error("word late");
    a_word_lsb: assert property (take0 |=> OUT_DATA_O[0] == $past(lsb))
        else $error("word lsb wrong");
    a_word_full: assert property (take0 |=> OUT_DATA_O == $past(exp_w))
        else $error("word framing wrong");
    a_stall_hold: assert property (OUT_VALID_O && !OUT_READY_I |=>
        OUT_VALID_O && $stable(OUT_DATA_O)) else $error("stalled word lost");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    a_err_unmapped: assert property (CYC_I && STB_I && !ACK_O && !ERR_O && !mapped
        |=> ERR_O && !ACK_O) else $error("unmapped not refused");
    c_marker: cover property (take0 && ctl_r[0] && cfg_r[3]);
    c_err: cover property (ERR_O);
    c_full: cover property (!SMP_READY_O);
endmodule

//--- verif/lsbm_sink_model.sv
// Link receiver model taking output words with random stalls
`timescale 1ns/1ps
module lsbm_sink_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Stream
    input  wire logic        stall,
    input  wire logic        valid,
    input  wire logic [11:0] data,
    output logic             ready,
    // Captured word
    output logic             got,
    output logic [11:0]      word
);
    int seed = 31;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
            got   <= 1'b0;
            word  <= 12'h000;
        end else begin
            got <= valid && ready;
            if (valid && ready)
                word <= data;
            ready <= !stall && ($random(seed) % 3 != 0);
        end
    end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the skew and marker block
`timescale 1ns/1ps
module testbench;
    logic        CLK_I, RST_N_I, CE_I, WE_I, CYC_I, STB_I, ACK_O, ERR_O, SKEW_B4_EN_O;
    logic [10:0] ADR_I;
    logic [31:0] DAT_I, DAT_O, rd;
    logic [3:0]  SEL_I;
    logic [7:0]  TRIM_B4_M90_I, TRIM_B5_P0_I, TRIM_B5_M90_I, SKEW_B4_O, SKEW_B5_O, ct, cf;
    logic [11:0] SMP_DATA_I, OUT_DATA_O, word;
    logic        SMP_MARKER_I, SMP_CAL_STATE_I, SMP_VALID_I, SMP_READY_O, OUT_VALID_O;
    logic        OUT_READY_I, stall, got, er;
    logic [1:0]  ILA_CS_O;
    logic [7:0]  tr[3], v[3];
    logic [8:0]  ix[3];
    logic [11:0] exp_q[$];
    int          seed = 75, num_errors = 0, n_tests = 0, n;
    ////////////////////////////////////////////////////////////////////////////
    lsbm_top u_lsbm_top (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .ADR_I(ADR_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I),
        .STB_I(STB_I), .ACK_O(ACK_O), .ERR_O(ERR_O), .TRIM_B4_M90_I(TRIM_B4_M90_I),
        .TRIM_B5_P0_I(TRIM_B5_P0_I), .TRIM_B5_M90_I(TRIM_B5_M90_I), .SKEW_B4_O(SKEW_B4_O),
        .SKEW_B4_EN_O(SKEW_B4_EN_O), .SKEW_B5_O(SKEW_B5_O), .SMP_DATA_I(SMP_DATA_I),
        .SMP_MARKER_I(SMP_MARKER_I), .SMP_CAL_STATE_I(SMP_CAL_STATE_I),
        .SMP_VALID_I(SMP_VALID_I), .SMP_READY_O(SMP_READY_O), .OUT_DATA_O(OUT_DATA_O),
        .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I), .ILA_CS_O(ILA_CS_O));
    lsbm_sink_model u_lsbm_sink_model (.clk(CLK_I), .rst_n(RST_N_I), .stall(stall),
        .valid(OUT_VALID_O), .data(OUT_DATA_O), .ready(OUT_READY_I), .got(got), .word(word));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // One classic Wishbone cycle, entered and left just after a rising edge
    task wb(input logic we, input logic [8:0] i, input logic [7:0] d, input logic [3:0] s);
        @(posedge CLK_I);
        {CYC_I, STB_I, WE_I} <= {2'b11, we};
        ADR_I <= {i, 2'b00};
        DAT_I <= {24'h0, d};
        SEL_I <= s;
        do @(posedge CLK_I); while (ACK_O !== 1'b1 && ERR_O !== 1'b1);
        rd = DAT_O;
        er = ERR_O;
        {CYC_I, STB_I, WE_I} <= 3'b000;
    endtask
    function automatic logic [11:0] fw(logic [11:0] d, logic m, logic c, logic [7:0] t, k);
        logic b;
        b = (t[0] && k[3]) ? m : (k[2] ? c : d[0]);
        return k[1] ? {4'h0, d[7:1], b} : {d[11:1], b};
    endfunction
    task send(input logic [11:0] d, input logic m, input logic c);
        SMP_DATA_I <= d;
        SMP_MARKER_I <= m;
        SMP_CAL_STATE_I <= c;
        SMP_VALID_I <= 1'b1;
        n = 0;
        do begin @(negedge CLK_I); n++; end while (SMP_READY_O !== 1'b1 && n < 100);
        @(posedge CLK_I);
        exp_q.push_back(fw(d, m, c, ct, cf));
    endtask
    task drain;
        n = 0;
        while (exp_q.size() > 0 && n < 300) begin @(negedge CLK_I); n++; end
        chk("words left", 0, exp_q.size());
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge CLK_I) begin
        if (got === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected word", 0, 1);
            else
                chk("out word", {20'h0, exp_q.pop_front()}, {20'h0, word});
        end
    end
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        num_errors++;
        end_of_test;
    end
    initial begin
        foreach (tr[i]) tr[i] = $random(seed);
        ix = '{lsbm_pkg::IDX_B4_SKEW_M90, lsbm_pkg::IDX_B5_SKEW_P0, lsbm_pkg::IDX_B5_SKEW_M90};
        {RST_N_I, WE_I, CYC_I, STB_I, SMP_MARKER_I, SMP_CAL_STATE_I, SMP_VALID_I} = '0;
        {CE_I, stall, ADR_I, DAT_I, SEL_I, SMP_DATA_I, ct, cf} = {1'b1, 76'h0};
        {TRIM_B4_M90_I, TRIM_B5_P0_I, TRIM_B5_M90_I} = {tr[0], tr[1], tr[2]};
        repeat (16) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        for (int i = 0; i < 3; i++) begin
            v[i] = $random(seed);
            wb(0, ix[i], 8'h00, 4'hf);
            chk("trim", tr[i], rd);
            wb(1, ix[i], v[i], 4'hf);
            wb(0, ix[i], 8'h00, 4'hf);
            chk("skew rw", v[i], rd);
        end
        wb(0, lsbm_pkg::IDX_LSB_CTRL, 8'h00, 4'hf);
        chk("ctrl reset", 0, rd);
        wb(1, lsbm_pkg::IDX_LSB_CTRL, 8'hff, 4'he);
        wb(0, lsbm_pkg::IDX_LSB_CTRL, 8'h00, 4'hf);
        chk("ctrl lane0 off", 0, rd);
        wb(0, 9'h161, 8'h00, 4'hf);
        chk("unmapped err", 1, er);
        for (int p = 0; p < 2; p++) begin
            wb(1, lsbm_pkg::IDX_CONFIG, p[7:0], 4'hf);
            @(negedge CLK_I);
            chk("b4 en", p[0], SKEW_B4_EN_O);
            chk("b4 skew", p ? v[0] : 8'h00, SKEW_B4_O);
            chk("b5 skew", p ? v[2] : v[1], SKEW_B5_O);
        end
        // Marker enable and receiver enable set together from k[0]; narrow and cal state swept by k[1] and k[2]
        for (int k = 0; k < 8; k++) begin
            ct = {7'h0, k[0]};
            cf = {4'h0, k[0], k[2], k[1], 1'b0};
            wb(1, lsbm_pkg::IDX_LSB_CTRL, ct, 4'hf);
            wb(1, lsbm_pkg::IDX_CONFIG, cf, 4'hf);
            wb(0, lsbm_pkg::IDX_CONFIG, 8'h00, 4'hf);
            chk("config rw", cf, rd);
            wb(0, lsbm_pkg::IDX_STATUS, 8'h00, 4'hf);
            chk("status", {4'h0, 1'b1, k[0], 2'b10}, rd);
            repeat (12) send($random(seed), $random(seed), $random(seed));
            SMP_VALID_I <= 1'b0;
            drain;
        end
        @(posedge CLK_I);
        stall <= 1'b1;
        repeat (2) @(posedge CLK_I);
        send(12'h5a5, 1'b1, 1'b0);
        send(12'ha5a, 1'b0, 1'b1);
        SMP_VALID_I <= 1'b0;
        repeat (3) @(negedge CLK_I);
        chk("buffer full", 0, SMP_READY_O);
        stall <= 1'b0;
        drain;
        @(posedge CLK_I);
        CE_I <= 1'b0;
        SMP_VALID_I <= 1'b1;
        repeat (3) @(negedge CLK_I);
        chk("ce freeze", 0, OUT_VALID_O);
        @(posedge CLK_I);
        {CE_I, SMP_VALID_I} <= 2'b10;
        repeat (3) @(negedge CLK_I);
        chk("ila cs", 0, ILA_CS_O);
        end_of_test;
    end
endmodule
bind lsbm_top lsbm_top_asserts u_lsbm_top_asserts (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
    .ADR_I(ADR_I), .DAT_I(DAT_I), .WE_I(WE_I), .SEL_I(SEL_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .ACK_O(ACK_O), .ERR_O(ERR_O), .TRIM_B4_M90_I(TRIM_B4_M90_I), .TRIM_B5_P0_I(TRIM_B5_P0_I),
    .TRIM_B5_M90_I(TRIM_B5_M90_I), .SKEW_B4_O(SKEW_B4_O), .SKEW_B4_EN_O(SKEW_B4_EN_O),
    .SKEW_B5_O(SKEW_B5_O), .SMP_DATA_I(SMP_DATA_I), .SMP_MARKER_I(SMP_MARKER_I),
    .SMP_CAL_STATE_I(SMP_CAL_STATE_I), .SMP_VALID_I(SMP_VALID_I), .SMP_READY_O(SMP_READY_O),
    .OUT_DATA_O(OUT_DATA_O), .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I),
    .ILA_CS_O(ILA_CS_O));
